// [logic/usb_serial_bridge_control.sv]
// Functional notes
// - Config-memory pins float during reset; serial clock is driven afterwards.
// - Serial clock pin pulled low in reset selects the alternate product identifier.
// - Select pin pulled low in reset selects 48MHz mode, unpulled selects 6MHz.
// - Suspend indicator is low while the link is suspended, high otherwise.
// - Power-switch enable goes low once configured, high while suspended.
// - Supply strap low means bus powered, high means self powered.
// - With pull-down option set and power off, interface lines are pulled low.
// - Pending receive data is flushed after a 1 to 255 ms programmed timeout.
// - Line driver enable stays asserted while a break is transmitted.
// - Prescaler divides by n from 2 upward plus a fraction in eighths.
// - Prescaler 1 gives 2 Mbaud, 0 gives 3 Mbaud, both without fraction.
// - Parallel mode turns the eight interface lines into a port, reversible.
// - In parallel mode host bytes reach the port paced by the prescaler.
// - Only the first 64 configuration words are read, larger memories ignored.
// - Absent memory reads blank and built-in defaults are used.
// - Stored option selects a 2.0 device descriptor, still full speed.
// - Absent, blank or invalid memory removes the serial number.
// - External active-low reset combines with the power-on reset.
// - Clear output floats 5 ms after reset ends, driven low during external reset, floating during power-on reset.
// - Sixteen-times baud enable is derived from the 48MHz reference figure.
`default_nettype none
module usb_serial_bridge_control
  import bridge_ctrl_pkg::*;
#(
  parameter int unsigned CLEAR_HOLD = CLEAR_HOLD_CYCLES,
  parameter int unsigned MS_TICK    = MS_TICK_CYCLES
) (
  // Clock and resets
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ext_reset_n,
  // Clear output
  output logic             clear_output_n_o,
  output logic             clear_output_n_oe,
  // Configuration memory pins
  input  wire logic        cfg_mem_select_i,
  output logic             cfg_mem_select_o,
  output logic             cfg_mem_select_oe,
  input  wire logic        cfg_mem_serial_clock_i,
  output logic             cfg_mem_serial_clock_o,
  output logic             cfg_mem_serial_clock_oe,
  input  wire logic        cfg_mem_data_io_i,
  output logic             cfg_mem_data_io_o,
  output logic             cfg_mem_data_io_oe,
  // Configuration results
  input  wire logic [5:0]  cfg_word_addr,
  output logic      [15:0] cfg_word_data,
  output logic             cfg_done,
  output logic             usb2_descriptor,
  output logic             serial_number_present,
  output logic             alt_product_id,
  output logic             clock_mode_48m,
  // Power control
  input  wire logic        usb_suspended,
  input  wire logic        usb_configured,
  input  wire logic        supply_source_strap,
  output logic             suspend_n,
  output logic             power_switch_enable_n,
  output logic             bus_powered,
  output logic             iface_pulldown,
  // Receive timeout
  input  wire logic [7:0]  rx_timeout_ms,
  input  wire logic        rx_data_pending,
  input  wire logic        rx_activity,
  output logic             rx_flush,
  // Serial engine
  input  wire logic        uart_txd,
  input  wire logic        uart_rts_n,
  input  wire logic        uart_dtr_n,
  input  wire logic        uart_tx_busy,
  input  wire logic        uart_break_active,
  input  wire logic        uart_char_idle,
  input  wire logic [13:0] baud_div_int,
  input  wire logic [2:0]  baud_div_frac,
  output logic             line_driver_enable,
  output logic             baud_x16_tick,
  // Parallel port
  input  wire logic        parallel_mode_req,
  input  wire logic [7:0]  port_dir,
  input  wire logic [7:0]  host_data,
  input  wire logic        host_valid,
  output logic             host_ready,
  output logic             parallel_active,
  input  wire logic [7:0]  iface_i,
  output logic      [7:0]  iface_o,
  output logic      [7:0]  iface_oe,
  output logic      [7:0]  port_read
);

  function automatic logic [16:0] div_eighths_of(input logic [13:0] n, input logic [2:0] f);
    if (n == 14'h0000) begin
      return DIV_EIGHTHS_3M;
    end else if (n == 14'h0001) begin
      return DIV_EIGHTHS_2M;
    end
    return {n, f};
  endfunction

  logic             dev_rst;
  logic [31:0]      clear_cnt;
  cfg_state_t       cfg_state;
  logic [31:0]      half_cnt;
  logic             half_en;
  logic [4:0]       bit_cnt;
  logic [5:0]       cfg_addr;
  logic [15:0]      shreg;
  logic [15:0]      word_sum;
  logic [15:0]      cfg_mem [CFG_WORDS];
  logic             pd_opt;
  logic [8:0]       cmd_word;
  logic             pwr_on;
  logic [31:0]      ms_cnt;
  logic             ms_tick;
  logic [7:0]       to_cnt;
  logic [7:0]       to_limit;
  logic [16:0]      div_eighths;
  logic [23:0]      cur_lim;
  logic [23:0]      acc;
  logic [23:0]      next_acc;
  logic [3:0]       os_cnt;
  logic [7:0]       port_latch;

  assign cmd_word = {CFG_READ_OP, cfg_addr};
  assign pwr_on   = usb_configured & ~usb_suspended;
  assign to_limit = (rx_timeout_ms == 8'h00) ? RX_TIMEOUT_MIN : rx_timeout_ms;
  assign cur_lim  = 24'(div_eighths) * LIM_SCALE;
  assign next_acc = acc + PHASE_STEP;

  // External reset is taken synchronously; power-on reset holds it set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dev_rst <= 1'b1;
    end else begin
      dev_rst <= ~ext_reset_n;
    end
  end

  // Clear output: floating in power-on reset, low in external reset, released for the hold time, then driven high.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clear_cnt         <= 32'h0;
      clear_output_n_o  <= 1'b0;
      clear_output_n_oe <= 1'b0;
    end else if (dev_rst) begin
      clear_cnt         <= 32'h0;
      clear_output_n_o  <= 1'b0;
      clear_output_n_oe <= 1'b1;
    end else if (clear_cnt != 32'(CLEAR_HOLD)) begin
      clear_cnt         <= clear_cnt + 32'h1;
      clear_output_n_oe <= 1'b0;
    end else begin
      clear_output_n_o  <= 1'b1;
      clear_output_n_oe <= 1'b1;
    end
  end

  // Straps are caught while reset holds the pins floating.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alt_product_id <= 1'b0;
      clock_mode_48m <= 1'b0;
    end else if (dev_rst) begin
      alt_product_id <= ~cfg_mem_serial_clock_i;
      clock_mode_48m <= ~cfg_mem_select_i;
    end
  end

  // Half-period enable for the configuration memory clock.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 32'h0;
      half_en  <= 1'b0;
    end else if (dev_rst || half_cnt == 32'(CFG_HALF_CYCLES - 1)) begin
      half_cnt <= 32'h0;
      half_en  <= ~dev_rst;
    end else begin
      half_cnt <= half_cnt + 32'h1;
      half_en  <= 1'b0;
    end
  end

  // Reads words 0..63 one by one; anything beyond is never addressed.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_state               <= CFG_START;
      bit_cnt                 <= 5'h0;
      cfg_addr                <= 6'h0;
      shreg                   <= 16'h0;
      word_sum                <= 16'h0;
      cfg_done                <= 1'b0;
      cfg_mem_select_o        <= 1'b0;
      cfg_mem_select_oe       <= 1'b0;
      cfg_mem_serial_clock_o  <= 1'b0;
      cfg_mem_serial_clock_oe <= 1'b0;
      cfg_mem_data_io_o       <= 1'b0;
      cfg_mem_data_io_oe      <= 1'b0;
    end else if (dev_rst) begin
      cfg_state               <= CFG_START;
      bit_cnt                 <= 5'h0;
      cfg_addr                <= 6'h0;
      word_sum                <= 16'h0;
      cfg_done                <= 1'b0;
      cfg_mem_select_oe       <= 1'b0;
      cfg_mem_serial_clock_oe <= 1'b0;
      // A read cut short must not leave the clock high or the memory selected.
      cfg_mem_select_o        <= 1'b0;
      cfg_mem_serial_clock_o  <= 1'b0;
      cfg_mem_data_io_oe      <= 1'b0;
    end else begin
      cfg_mem_select_oe       <= 1'b1;
      cfg_mem_serial_clock_oe <= 1'b1;
      if (half_en) begin
        case (cfg_state)
          CFG_START: begin
            cfg_mem_select_o   <= 1'b1;
            cfg_mem_data_io_o  <= cmd_word[8];
            cfg_mem_data_io_oe <= 1'b1;
            bit_cnt            <= 5'h0;
            cfg_state          <= CFG_SHIFT;
          end
          CFG_SHIFT: begin
            if (!cfg_mem_serial_clock_o) begin
              cfg_mem_serial_clock_o <= 1'b1;
              if (bit_cnt >= CFG_CMD_BITS) begin
                shreg <= {shreg[14:0], cfg_mem_data_io_i};
              end
            end else begin
              cfg_mem_serial_clock_o <= 1'b0;
              bit_cnt                <= bit_cnt + 5'h1;
              if (bit_cnt + 5'h1 < CFG_CMD_BITS) begin
                cfg_mem_data_io_o <= cmd_word[4'(CFG_CMD_BITS - bit_cnt - 5'h2)];
              end else begin
                cfg_mem_data_io_oe <= 1'b0;
              end
              if (bit_cnt == CFG_LAST_BIT) begin
                cfg_state <= CFG_NEXT;
              end
            end
          end
          CFG_NEXT: begin
            cfg_mem_select_o <= 1'b0;
            if (cfg_addr == CFG_LAST_ADDR) begin
              cfg_state <= CFG_DONE;
            end else begin
              word_sum  <= word_sum + shreg;
              cfg_addr  <= cfg_addr + 6'h1;
              cfg_state <= CFG_START;
            end
          end
          CFG_DONE: begin
            cfg_done <= 1'b1;
          end
          default: begin
            cfg_state <= CFG_START;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (half_en && cfg_state == CFG_NEXT) begin
      cfg_mem[cfg_addr] <= shreg;
    end
    cfg_word_data <= cfg_mem[cfg_word_addr];
  end

  // Options only count when the contents are neither blank nor failing the sum.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usb2_descriptor       <= 1'b0;
      serial_number_present <= 1'b0;
      pd_opt                <= 1'b0;
    end else if (dev_rst) begin
      usb2_descriptor       <= 1'b0;
      serial_number_present <= 1'b0;
      pd_opt                <= 1'b0;
    end else if (half_en && cfg_state == CFG_DONE && !cfg_done) begin
      if (cfg_mem[CFG_OPT_WORD] != CFG_BLANK_WORD && word_sum == cfg_mem[CFG_LAST_ADDR]) begin
        usb2_descriptor       <= cfg_mem[CFG_OPT_WORD][OPT_USB2_BIT];
        serial_number_present <= 1'b1;
        pd_opt                <= cfg_mem[CFG_OPT_WORD][OPT_PULLDOWN_BIT];
      end else begin
        serial_number_present <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      suspend_n             <= 1'b1;
      power_switch_enable_n <= 1'b1;
      bus_powered           <= 1'b0;
      iface_pulldown        <= 1'b0;
    end else begin
      suspend_n             <= ~usb_suspended;
      power_switch_enable_n <= ~pwr_on;
      bus_powered           <= ~supply_source_strap;
      iface_pulldown        <= pd_opt & ~pwr_on;
    end
  end

  // Millisecond tick and receive flush timer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 32'(MS_TICK - 1)) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt   <= 8'h0;
      rx_flush <= 1'b0;
    end else if (rx_activity || !rx_data_pending) begin
      to_cnt   <= 8'h0;
      rx_flush <= 1'b0;
    end else if (ms_tick && to_cnt + 8'h1 >= to_limit) begin
      to_cnt   <= 8'h0;
      rx_flush <= 1'b1;
    end else begin
      to_cnt   <= ms_tick ? to_cnt + 8'h1 : to_cnt;
      rx_flush <= 1'b0;
    end
  end

  // Divisor and mode are only taken over while no character is in flight.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_eighths     <= DIV_EIGHTHS_RST;
      parallel_active <= 1'b0;
    end else if (uart_char_idle) begin
      div_eighths     <= div_eighths_of(baud_div_int, baud_div_frac);
      parallel_active <= parallel_mode_req;
    end
  end

  // Phase accumulator in reference eighths; saturates at one tick a cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc           <= 24'h0;
      baud_x16_tick <= 1'b0;
      os_cnt        <= 4'h0;
    end else if (next_acc >= cur_lim) begin
      acc           <= (next_acc >= {cur_lim[22:0], 1'b0}) ? 24'h0 : next_acc - cur_lim;
      baud_x16_tick <= 1'b1;
      os_cnt        <= os_cnt + 4'h1;
    end else begin
      acc           <= next_acc;
      baud_x16_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_driver_enable <= 1'b0;
    end else begin
      line_driver_enable <= ~parallel_active & (uart_tx_busy | uart_break_active);
    end
  end

  // One host byte per bit period reaches the port.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_ready <= 1'b0;
      port_latch <= 8'h0;
    end else if (!parallel_active) begin
      host_ready <= 1'b0;
    end else if (host_valid && host_ready) begin
      host_ready <= 1'b0;
      port_latch <= host_data;
    end else if (baud_x16_tick && os_cnt == OVERSAMPLE_LAST) begin
      host_ready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      iface_o   <= 8'h0;
      iface_oe  <= 8'h0;
      port_read <= 8'h0;
    end else begin
      port_read <= iface_i;
      if (parallel_active) begin
        iface_o  <= port_latch;
        iface_oe <= port_dir;
      end else begin
        iface_o  <= {3'h0, uart_dtr_n, 1'b0, uart_rts_n, 1'b0, uart_txd};
        iface_oe <= SERIAL_OE_MASK;
      end
    end
  end

  cfg_float_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      dev_rst |=> !cfg_mem_select_oe && !cfg_mem_serial_clock_oe && !cfg_mem_data_io_oe)
    else $error("config pins driven in reset");
  cfg_clock_drive_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(dev_rst) |=> cfg_mem_serial_clock_oe [*3])
    else $error("config clock not driven after reset");
  product_strap_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      dev_rst |=> alt_product_id == !$past(cfg_mem_serial_clock_i))
    else $error("product strap wrong");
  clock_strap_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 $fell(dev_rst) |-> clock_mode_48m == !$past(cfg_mem_select_i))
    else $error("clock strap wrong");
  suspend_out_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      usb_suspended |=> !suspend_n && power_switch_enable_n)
    else $error("suspend outputs wrong");
  power_switch_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_switch_enable_n |-> $past(usb_configured) && !$past(usb_suspended))
    else $error("power switch on without configuration");
  supply_strap_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 1'b1 |-> bus_powered != $past(supply_source_strap))
    else $error("supply strap wrong");
  pulldown_gate_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      iface_pulldown |-> power_switch_enable_n && $past(pd_opt))
    else $error("pulldown while powered");
  flush_cause_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_flush |-> $past(rx_data_pending) && $past(ms_tick) && !$past(rx_activity))
    else $error("flush without pending data");
  flush_restart_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_flush |=> !rx_flush && to_cnt == 8'h0)
    else $error("timer not restarted");
  break_enable_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      uart_break_active && !parallel_active |=> line_driver_enable)
    else $error("driver enable dropped during break");
  divisor_take_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      uart_char_idle && baud_div_int == 14'h0001 |=> div_eighths == DIV_EIGHTHS_2M)
    else $error("2 Mbaud divisor wrong");
  boundary_hold_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !uart_char_idle |=> $stable(div_eighths) && $stable(parallel_active))
    else $error("divisor changed mid character");
  host_pace_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      host_valid && host_ready |=> !host_ready ##1 iface_o == $past(host_data, 2) || !parallel_active)
    else $error("host byte not paced");
  serial_blank_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cfg_done && cfg_mem[CFG_OPT_WORD] == CFG_BLANK_WORD |-> !serial_number_present)
    else $error("serial number on blank memory");
  descriptor_valid_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      usb2_descriptor |-> serial_number_present)
    else $error("descriptor option without valid memory");
  clear_low_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      dev_rst |=> clear_output_n_oe && !clear_output_n_o)
    else $error("clear output not low in reset");

endmodule
`default_nettype wire

// [logic/bridge_ctrl_pkg.sv]
`default_nettype none
package bridge_ctrl_pkg;
  // System clock figures.
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned SYS_CLK_MHZ       = 10;
  localparam int unsigned NS_PER_MS         = 1_000_000;
  // Clear output stays released this long after reset ends.
  localparam int unsigned CLEAR_HOLD_MS     = 5;
  localparam int unsigned CLEAR_HOLD_CYCLES = CLEAR_HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Receive timeout step.
  localparam int unsigned RX_STEP_MS        = 1;
  localparam int unsigned MS_TICK_CYCLES    = RX_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [7:0]  RX_TIMEOUT_MIN    = 8'h01;
  // Configuration memory serial clock half period.
  localparam int unsigned CFG_HALF_NS       = 500;
  localparam int unsigned CFG_HALF_CYCLES   = (CFG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CFG_WORDS         = 64;
  localparam logic [5:0]  CFG_LAST_ADDR     = 6'h3f;
  localparam logic [2:0]  CFG_READ_OP       = 3'h6;
  localparam logic [4:0]  CFG_CMD_BITS      = 5'h09;
  localparam logic [4:0]  CFG_LAST_BIT      = 5'h18;
  localparam logic [15:0] CFG_BLANK_WORD    = 16'hffff;
  localparam logic [5:0]  CFG_OPT_WORD      = 6'h00;
  localparam int unsigned OPT_USB2_BIT      = 0;
  localparam int unsigned OPT_PULLDOWN_BIT  = 1;
  // Baud generator: reference rate against the system rate, in eighths.
  localparam int unsigned REF_CLK_MHZ       = 48;
  localparam logic [23:0] PHASE_STEP        = 24'(REF_CLK_MHZ * 8);
  localparam logic [23:0] LIM_SCALE         = 24'(SYS_CLK_MHZ);
  localparam logic [16:0] DIV_EIGHTHS_3M    = 17'h00008;
  localparam logic [16:0] DIV_EIGHTHS_2M    = 17'h0000c;
  localparam logic [16:0] DIV_EIGHTHS_RST   = 17'h00010;
  localparam logic [3:0]  OVERSAMPLE_LAST   = 4'hf;
  // Serial-mode pin map on the shared interface port.
  localparam logic [7:0]  SERIAL_OE_MASK    = 8'h15;

  typedef enum logic [3:0] {
    CFG_START = 4'b0001,
    CFG_SHIFT = 4'b0010,
    CFG_NEXT  = 4'b0100,
    CFG_DONE  = 4'b1000
  } cfg_state_t;
endpackage
`default_nettype wire

// [sim/cfg_mem_model.sv]
`default_nettype none
module cfg_mem_model (
  // Memory pins as seen on the wires
  input  wire logic sel,
  input  wire logic sk,
  input  wire logic di,
  input  wire logic present,
  output logic      dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [15:0] sh;
  logic [5:0]  addr;
  int          cnt;
  initial begin
    dout = 1'b1;
    cnt = 0;
  end
  // Command and address bits are taken on the rising serial clock.
  always @(posedge sk) if (sel) begin
    if (cnt >= 3 && cnt < 9) addr = {addr[4:0], di};
    cnt = cnt + 1;
    if (cnt == 9) sh = mem[addr];
  end
  // Data changes on the falling clock so it is steady at the next rise.
  always @(negedge sk) if (sel && cnt >= 9 && present) begin
    dout = sh[15];
    sh = {sh[14:0], 1'b1};
  end
  // A released data line floats up to the pull-up level.
  always @(negedge sel) begin
    cnt = 0;
    dout = 1'b1;
  end
endmodule
`default_nettype wire

// [sim/test_usb_serial_bridge_control.sv]
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_usb_serial_bridge_control
  import bridge_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [35:0] e; logic [35:0] m;} note_t;
  logic clk_sys = 0, rst_n = 0, ext_reset_n = 1, sel_pull = 0, sk_pull = 0, present = 1;
  logic usb_suspended = 0, usb_configured = 0, supply_source_strap = 0, rx_data_pending = 0;
  logic rx_activity = 0, uart_txd = 1, uart_rts_n = 1, uart_dtr_n = 1, uart_tx_busy = 0;
  logic uart_break_active = 0, uart_char_idle = 1, parallel_mode_req = 0, host_valid = 0;
  logic look = 0;
  logic [5:0]  cfg_word_addr = 0;
  logic [7:0]  rx_timeout_ms = 8'h03, port_dir = 8'hff, host_data = 0, iface_i = 0;
  logic [13:0] baud_div_int = 14'h0002;
  logic [2:0]  baud_div_frac = 0;
  wire logic clear_output_n_o, clear_output_n_oe, cfg_mem_select_o, cfg_mem_select_oe;
  wire logic cfg_mem_serial_clock_o, cfg_mem_serial_clock_oe, cfg_mem_data_io_o;
  wire logic cfg_mem_data_io_oe, cfg_done, usb2_descriptor, serial_number_present;
  wire logic alt_product_id, clock_mode_48m, suspend_n, power_switch_enable_n, bus_powered;
  wire logic iface_pulldown, rx_flush, line_driver_enable, baud_x16_tick, host_ready;
  wire logic parallel_active, mem_out;
  wire logic [15:0] cfg_word_data;
  wire logic [7:0]  iface_o, iface_oe, port_read;
  wire logic cfg_mem_select_i = cfg_mem_select_oe ? cfg_mem_select_o : sel_pull;
  wire logic cfg_mem_serial_clock_i = cfg_mem_serial_clock_oe ? cfg_mem_serial_clock_o : sk_pull;
  wire logic cfg_mem_data_io_i = cfg_mem_data_io_oe ? cfg_mem_data_io_o : mem_out;
  wire logic [35:0] obs = {iface_oe, iface_o, cfg_word_data, suspend_n, power_switch_enable_n,
                           bus_powered, iface_pulldown};
  int fail_count = 0, n_checks = 0, seed = 1957, c;
  int bi[4] = '{1, 100, 100, 40}, bf[4] = '{7, 4, 0, 0}, bd[4] = '{1, 1, 1, 0};
  int eff = 12, ex;
  logic [31:0] v;
  logic [15:0] sum;
  time t1;
  note_t q[$];
  usb_serial_bridge_control #(.CLEAR_HOLD(20), .MS_TICK(10)) uut (.*);
  cfg_mem_model mdl (.sel(cfg_mem_select_i), .sk(cfg_mem_serial_clock_i),
                     .di(cfg_mem_data_io_i), .present(present), .dout(mem_out));
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (look === 1'b1 && q.size() > 0) begin
    note_t n;
    n = q.pop_front();
    `CHK(n.nm, n.e, obs & n.m)
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic note(string nm, logic [35:0] e, logic [35:0] m);
    q.push_back('{nm, e & m, m});
    look = 1;
    tick(1);
    look = 0;
  endtask
  task automatic wait_cfg();
    for (c = 0; c < 20000 && cfg_done !== 1'b1; c++) tick(1);
    `CHK("cfg_done", 1'b1, cfg_done)
  endtask
  task automatic send(logic [7:0] b);
    host_data = b;
    host_valid = 1;
    do @(posedge clk_sys); while (host_ready !== 1'b1);
    t1 = $time;
    #5;
    host_valid = 0;
    tick(1);
    note("port_byte", {8'hff, b, 20'h0}, {16'hffff, 20'h0});
  endtask
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #8_000_000;
    fail_count++;
    results();
  end
  initial begin
    sum = 0;
    for (int i = 0; i < 256; i++) mdl.mem[i] = (i == 0) ? 16'h0003 : 16'($random(seed));
    for (int i = 0; i < 63; i++) sum = sum + mdl.mem[i];
    mdl.mem[63] = sum;
    iface_i = 8'($random(seed));
    tick(2);
    `CHK("pins_float", 3'h0, {cfg_mem_select_oe, cfg_mem_serial_clock_oe, cfg_mem_data_io_oe})
    `CHK("clear_float", 1'b0, clear_output_n_oe)
    tick(1);
    rst_n = 1;
    tick(10);
    `CHK("clear_hold", 1'b0, clear_output_n_oe)
    tick(30);
    `CHK("clear_up", 2'h3, {clear_output_n_oe, clear_output_n_o})
    `CHK("straps", 2'h3, {alt_product_id, clock_mode_48m})
    `CHK("sk_driven", 1'b1, cfg_mem_serial_clock_oe)
    `CHK("port_read", iface_i, port_read)
    wait_cfg();
    `CHK("options", 2'h3, {usb2_descriptor, serial_number_present})
    for (int a = 0; a < 64; a++) begin
      cfg_word_addr = 6'(a);
      tick(1);
      note("cfg_word", {16'h0, mdl.mem[a], 4'h0}, 36'h00ffff0);
    end
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      {supply_source_strap, usb_suspended, usb_configured} = v[2:0];
      tick(1);
      note("power", {!v[1], !(v[0] && !v[1]), !v[2], !(v[0] && !v[1])}, 36'hf);
    end
    rx_data_pending = 1;
    for (c = 0; c < 100 && rx_flush !== 1'b1; c++) tick(1);
    `CHK("flush_span", 1'b1, c >= 20 && c <= 32)
    rx_activity = 1;
    tick(1);
    for (c = 0; c < 40 && rx_flush !== 1'b1; c++) tick(1);
    `CHK("flush_held", 1'b0, rx_flush)
    rx_data_pending = 0;
    rx_activity = 0;
    for (int r = 0; r < 4; r++) begin
      {baud_div_int, baud_div_frac, uart_char_idle} = {14'(bi[r]), 3'(bf[r]), 1'(bd[r])};
      if (bd[r] == 1) eff = (bi[r] < 2) ? 8 + 4 * bi[r] : bi[r] * 8 + bf[r];
      tick(20);
      c = 0;
      repeat (5000) begin
        tick(1);
        if (baud_x16_tick === 1'b1) c++;
      end
      ex = (192000 / eff > 5000) ? 5000 : 192000 / eff;
      `CHK("baud_rate", 1'b1, c >= ex - 1 && c <= ex + 1)
    end
    {baud_div_int, uart_char_idle, parallel_mode_req} = {14'd100, 1'b1, 1'b1};
    for (c = 0; c < 50 && parallel_active !== 1'b1; c++) tick(1);
    `CHK("parallel_on", 1'b1, parallel_active)
    send(8'ha5);
    ex = int'(t1 / 100);
    send(8'h3c);
    c = int'(t1 / 100) - ex;
    `CHK("byte_pace", 1'b1, c >= 320 && c <= 345)
    parallel_mode_req = 0;
    uart_txd = v[5];
    tick(5);
    `CHK("serial_back", {1'b0, SERIAL_OE_MASK, v[5]}, {parallel_active, iface_oe, iface_o[0]})
    uart_break_active = 1;
    tick(3);
    `CHK("break_enable", 1'b1, line_driver_enable)
    {sel_pull, present, sk_pull, ext_reset_n} = 4'ha;
    tick(3);
    `CHK("ext_clear", 2'h2, {clear_output_n_oe, clear_output_n_o})
    `CHK("ext_float", 1'b0, cfg_mem_data_io_oe)
    ext_reset_n = 1;
    tick(2);
    wait_cfg();
    `CHK("no_memory", 4'h0, {usb2_descriptor, serial_number_present, alt_product_id, clock_mode_48m})
    results();
  end
endmodule
`default_nettype wire
